/* File: rtl/pcs_phase_fifo_clocking.sv */
// How it works
// R1 - With rate matching, the recovered low-speed clock paces capture of the receive word.
// R2 - With rate matching, decode, byte deserializing and receive FIFO writes follow the tx clock.
// R3 - With the byte deserializer on, the receive FIFO is written at half the low-speed rate.
// R4 - The transmit low-speed clock is exported to the fabric as an output clock.
// R5 - The transmit FIFO write side follows automatic selection or the user core clock.
// R6 - Non-bonded automatic mode writes and reads the transmit FIFO on the tx low-speed clock.
// R7 - Bonded automatic mode writes and reads the transmit FIFO on the common bonded clock.
// R8 - A user transmit core clock must have exactly the read clock frequency.
// R9 - The receive FIFO read side follows automatic selection or the user core clock.
// R10 - Non-bonded with rate matching reads the receive FIFO on the tx low-speed clock.
// R11 - Non-bonded without rate matching reads and writes the receive FIFO on the recovered clock.
// R12 - The fabric side is 8, 10, 16 or 20 bits wide and the PMA side 8 or 10 bits.
// R13 - The transmitter can send the repeating K28.5, D21.5, K28.5, D10.2 compliance pattern.
// R14 - Forced disparity accompanies the K28.5 and D21.5 pair of the compliance pattern.
// R15 - A receive FIFO error output is high while that FIFO is full or empty, on its read clock.
// R16 - Both phase FIFOs use gray-coded pointers so write and read sides may differ in phase.
`include "pcs_clk_map.svh"
`default_nettype none

module phase_fifo #(
  parameter int W = 23,
  parameter int AW = 3
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  input wire logic rd,
  output logic [W-1:0] rdata,
  output logic full,
  output logic empty
);
  logic [W-1:0] mem [2**AW];
  logic [AW:0] wbin_r, rbin_r, wbin_nxt, rbin_nxt, wg, rg;

  always_comb begin
    wg = wbin_r ^ (wbin_r >> 1);
    rg = rbin_r ^ (rbin_r >> 1);
    empty = (wg == rg); // R16
    full = (wg == {~rg[AW:AW-1], rg[AW-2:0]}); // R16
    wbin_nxt = wbin_r + (AW+1)'(wr && !full);
    rbin_nxt = rbin_r + (AW+1)'(rd && !empty);
    rdata = mem[rbin_r[AW-1:0]];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wbin_r <= '0;
      rbin_r <= '0;
    end else if (ce) begin
      wbin_r <= wbin_nxt;
      rbin_r <= rbin_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (ce && wr && !full) begin
      mem[wbin_r[AW-1:0]] <= wdata;
    end
  end
endmodule

module pcs_phase_fifo_clocking
  import pcs_clk_pkg::*;
#(
  parameter int PW = 10,
  parameter int AW = 3
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Channel configuration
  input wire logic rate_match_en,
  input wire logic byte_deser_en,
  input wire logic bonded,
  input wire logic tx_coreclk_en,
  input wire logic rx_coreclk_en,
  input wire logic [1:0] width_sel,
  input wire logic compliance_en,
  // Clock sources
  input wire logic tx_ls_tick,
  input wire logic bond_tick,
  input wire logic rec_clk,
  input wire logic tx_coreclk,
  input wire logic rx_coreclk,
  // Fabric transmit
  input wire logic tx_valid,
  input wire logic [2*PW-1:0] tx_data,
  input wire logic [1:0] tx_k,
  input wire logic tx_forcedisp,
  // PMA transmit
  output logic [PW-1:0] pma_tx_data_r,
  output logic pma_tx_k_r,
  output logic pma_tx_force_r,
  // PMA receive
  input wire logic [PW-1:0] rx_pma_data,
  // Fabric receive and clocks
  output logic [2*PW-1:0] rx_data_r,
  output logic rx_valid_r,
  output logic rx_err_r,
  output logic tx_clkout_r,
  output logic rx_clkout_r
);
  localparam int DW = 2 * PW;
  localparam int TW = DW + 3;

  function automatic logic [DW-1:0] wmask(input logic [1:0] sel);
    unique case (sel)
      `WSEL_8: wmask = DW'(`MASK_8);
      `WSEL_10: wmask = DW'(`MASK_10);
      `WSEL_16: wmask = DW'(`MASK_16);
      `WSEL_20: wmask = DW'(`MASK_20);
    endcase
  endfunction

  function automatic cp_state_t cp_next(input cp_state_t s);
    unique case (s)
      CP_K0: cp_next = CP_D215;
      CP_D215: cp_next = CP_K1;
      CP_K1: cp_next = CP_D102;
      CP_D102: cp_next = CP_K0;
    endcase
  endfunction

  function automatic logic [PW-1:0] cp_code(input cp_state_t s);
    unique case (s)
      CP_K0, CP_K1: cp_code = PW'(`CODE_K285);
      CP_D215: cp_code = PW'(`CODE_D215);
      CP_D102: cp_code = PW'(`CODE_D102);
    endcase
  endfunction

  // Pin synchronisers, change taken once stages two and three agree
  logic [`PIN_NUM-1:0] pin_in, pin_tick;
  assign pin_in = {rx_coreclk, tx_coreclk, rec_clk};
  genvar g;
  for (g = 0; g < `PIN_NUM; g++) begin : g_sync
    logic [2:0] s_r, s_nxt;
    logic l_r, l_nxt;
    always_comb begin
      s_nxt = {s_r[1:0], pin_in[g]};
      l_nxt = (s_r[1] == s_r[2]) ? s_r[2] : l_r;
    end
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        s_r <= '0;
        l_r <= 1'b0;
      end else if (ce) begin
        s_r <= s_nxt;
        l_r <= l_nxt;
      end
    end
    assign pin_tick[g] = l_nxt && !l_r;
  end

  // Clock selection
  logic rec_tick, tx_rd_tick, tx_wr_tick, st_tick, rx_rd_tick;
  always_comb begin
    rec_tick = pin_tick[`PIN_REC];
    tx_rd_tick = bonded ? bond_tick : tx_ls_tick; // R6 R7
    tx_wr_tick = tx_coreclk_en ? pin_tick[`PIN_TXC] : tx_rd_tick; // R5 R6 R7 R8
    st_tick = rate_match_en ? tx_ls_tick : rec_tick; // R2 R11
    rx_rd_tick = rx_coreclk_en ? pin_tick[`PIN_RXC] : st_tick; // R9 R10 R11
  end

  // Transmit write side with compliance generator
  cp_state_t cp_r, cp_nxt;
  logic tx_wr;
  logic [TW-1:0] tx_wd;
  logic [PW-1:0] c_lo, c_hi;
  logic txf_full, txf_empty, tx_pop;
  logic [TW-1:0] txf_q;
  always_comb begin
    c_lo = cp_code(cp_r);
    c_hi = cp_code(cp_next(cp_r));
    cp_nxt = cp_r;
    tx_wr = tx_wr_tick && (tx_valid || compliance_en);
    tx_wd = {tx_forcedisp, tx_k, tx_data & wmask(width_sel)};
    if (compliance_en) begin
      if (width_sel[1]) begin
        tx_wd = {cp_r == CP_K0, 1'b0, 1'b1, c_hi, c_lo}; // R13 R14
        cp_nxt = cp_next(cp_next(cp_r)); // R13
      end else begin
        tx_wd = {cp_r == CP_K0 || cp_r == CP_D215, 1'b0, ~^cp_r, PW'(0), c_lo}; // R13 R14
        cp_nxt = cp_next(cp_r); // R13
      end
    end
    if (!tx_wr || !compliance_en) begin
      cp_nxt = compliance_en ? cp_r : CP_K0;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cp_r <= CP_K0;
    end else if (ce) begin
      cp_r <= cp_nxt;
    end
  end

  phase_fifo #(.W(TW), .AW(AW)) u_txf (
    .mclk(mclk), .rst(rst), .ce(ce), .wr(tx_wr), .wdata(tx_wd),
    .rd(tx_pop), .rdata(txf_q), .full(txf_full), .empty(txf_empty)
  );

  // Transmit read side toward the PMA, halves split when serializing bytes
  logic thi_r, thi_nxt, pk_nxt, pf_nxt;
  logic [TW-1:0] thold_r, thold_nxt;
  logic [PW-1:0] pd_nxt;
  always_comb begin
    tx_pop = 1'b0;
    thi_nxt = thi_r;
    thold_nxt = thold_r;
    pd_nxt = pma_tx_data_r;
    pk_nxt = pma_tx_k_r;
    pf_nxt = pma_tx_force_r;
    if (tx_rd_tick) begin
      if (byte_deser_en && thi_r) begin
        pd_nxt = thold_r[DW-1:PW];
        pk_nxt = thold_r[DW+1];
        thi_nxt = 1'b0;
      end else if (!txf_empty) begin
        tx_pop = 1'b1; // R6 R7
        thold_nxt = txf_q;
        pd_nxt = txf_q[PW-1:0];
        pk_nxt = txf_q[DW];
        pf_nxt = txf_q[DW+2];
        thi_nxt = byte_deser_en;
      end else begin
        pd_nxt = '0;
        pk_nxt = 1'b0;
        pf_nxt = 1'b0;
      end
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      thi_r <= 1'b0;
      thold_r <= '0;
      pma_tx_data_r <= '0;
      pma_tx_k_r <= 1'b0;
      pma_tx_force_r <= 1'b0;
    end else if (ce) begin
      thi_r <= thi_nxt;
      thold_r <= thold_nxt;
      pma_tx_data_r <= pd_nxt;
      pma_tx_k_r <= pk_nxt;
      pma_tx_force_r <= pf_nxt;
    end
  end

  // Receive capture, byte deserializer and FIFO write
  logic [PW-1:0] rx_in_r, rx_in_nxt, rlo_r, rlo_nxt;
  logic rhalf_r, rhalf_nxt, rx_wr;
  logic [DW-1:0] rx_wd, rxf_q;
  logic rxf_full, rxf_empty, rx_pop;
  always_comb begin
    rx_in_nxt = rec_tick ? rx_pma_data : rx_in_r; // R1
    rlo_nxt = rlo_r;
    rhalf_nxt = rhalf_r;
    rx_wr = 1'b0;
    rx_wd = '0;
    if (st_tick) begin
      if (!byte_deser_en) begin
        rx_wr = 1'b1; // R2
        rx_wd = {PW'(0), rx_in_r};
        rhalf_nxt = 1'b0;
      end else if (!rhalf_r) begin
        rlo_nxt = rx_in_r;
        rhalf_nxt = 1'b1;
      end else begin
        rx_wr = 1'b1; // R3
        rx_wd = {rx_in_r, rlo_r};
        rhalf_nxt = 1'b0;
      end
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_in_r <= '0;
      rlo_r <= '0;
      rhalf_r <= 1'b0;
    end else if (ce) begin
      rx_in_r <= rx_in_nxt;
      rlo_r <= rlo_nxt;
      rhalf_r <= rhalf_nxt;
    end
  end

  phase_fifo #(.W(DW), .AW(AW)) u_rxf (
    .mclk(mclk), .rst(rst), .ce(ce), .wr(rx_wr), .wdata(rx_wd),
    .rd(rx_pop), .rdata(rxf_q), .full(rxf_full), .empty(rxf_empty)
  );

  // Receive read side, error flag and exported clocks
  logic [DW-1:0] rd_nxt;
  logic rv_nxt, re_nxt, tc_nxt, rc_nxt;
  always_comb begin
    rx_pop = rx_rd_tick && !rxf_empty;
    rd_nxt = rx_pop ? (rxf_q & wmask(width_sel)) : rx_data_r; // R12
    rv_nxt = rx_pop;
    re_nxt = rx_rd_tick ? (rxf_full || rxf_empty) : rx_err_r; // R15
    tc_nxt = tx_ls_tick ? !tx_clkout_r : tx_clkout_r; // R4
    rc_nxt = rec_tick ? !rx_clkout_r : rx_clkout_r; // R11
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_data_r <= '0;
      rx_valid_r <= 1'b0;
      rx_err_r <= 1'b1;
      tx_clkout_r <= 1'b0;
      rx_clkout_r <= 1'b0;
    end else if (ce) begin
      rx_data_r <= rd_nxt;
      rx_valid_r <= rv_nxt;
      rx_err_r <= re_nxt;
      tx_clkout_r <= tc_nxt;
      rx_clkout_r <= rc_nxt;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_cp_k0;
    ce && compliance_en && !width_sel[1] && tx_wr_tick && cp_r == CP_K0;
  endsequence
  sequence s_cp_d215;
    ce && compliance_en && tx_wr_tick && cp_r == CP_D215;
  endsequence

  a_rec_capture: assert property (ce && rec_tick |=> rx_in_r == $past(rx_pma_data)) // R1
    else $error("recovered tick did not capture receive word");
  a_stage_rm: assert property (rate_match_en && !byte_deser_en && tx_ls_tick |-> rx_wr) // R2
    else $error("rate match stage not on tx clock");
  a_deser_half: assert property (rx_wr && byte_deser_en |-> rhalf_r && st_tick) // R3
    else $error("deserializer wrote on first half");
  a_txclk_out: assert property (ce && tx_ls_tick |=> tx_clkout_r != $past(tx_clkout_r)) // R4
    else $error("tx clock out did not toggle");
  a_tx_user: assert property (tx_coreclk_en |-> tx_wr_tick == pin_tick[`PIN_TXC]) // R5
    else $error("user tx core clock not selected");
  a_tx_nonbond: assert property (!bonded && !tx_coreclk_en |-> tx_wr_tick == tx_ls_tick) // R6
    else $error("non-bonded tx write clock wrong");
  a_tx_bond: assert property (bonded |-> tx_rd_tick == bond_tick) // R7
    else $error("bonded tx read clock wrong");
  a_rx_rm_rd: assert property (!rx_coreclk_en && rate_match_en |-> rx_rd_tick == tx_ls_tick) // R10
    else $error("rx read clock not tx clock");
  a_rx_rec_rd: assert property (!rx_coreclk_en && !rate_match_en |-> rx_rd_tick == rec_tick) // R11
    else $error("rx read clock not recovered clock");
  a_rx_user: assert property (rx_coreclk_en |-> rx_rd_tick == pin_tick[`PIN_RXC]) // R9
    else $error("user rx core clock not selected");
  a_rx_width: assert property ((rx_data_r & ~wmask(width_sel)) == '0 || $changed(width_sel)) // R12
    else $error("rx data wider than selected width");
  a_cp_order: assert property (s_cp_k0 |-> tx_wd[DW+2] && tx_wd[DW] ##1 cp_r == CP_D215) // R13
    else $error("compliance pattern out of order");
  a_cp_force: assert property (s_cp_d215 |-> tx_wd[DW+2] && tx_wd[7:0] == `CODE_D215) // R14
    else $error("forced disparity missing on D21.5");
  a_rx_err: assert property (ce && rx_rd_tick && rxf_empty |=> rx_err_r [*1]) // R15
    else $error("rx error low while fifo empty");
  a_fifo_ptr: assert property (ce && rx_wr && !rxf_full && !rx_pop |=> !rxf_empty) // R16
    else $error("rx fifo pointer did not advance");
endmodule

`default_nettype wire

/* File: rtl/pcs_clk_map.svh */
`ifndef PCS_CLK_MAP_SVH
`define PCS_CLK_MAP_SVH

// Fabric width selection codes
`define WSEL_8 2'h0
`define WSEL_10 2'h1
`define WSEL_16 2'h2
`define WSEL_20 2'h3

// Fabric width masks
`define MASK_8 20'h000FF
`define MASK_10 20'h003FF
`define MASK_16 20'h0FFFF
`define MASK_20 20'hFFFFF

// Compliance code groups
`define CODE_K285 8'hBC
`define CODE_D215 8'hB5
`define CODE_D102 8'h4A

// Synchronised pin indices
`define PIN_REC 0
`define PIN_TXC 1
`define PIN_RXC 2
`define PIN_NUM 3

`endif

/* File: rtl/pcs_clk_pkg.sv */
`default_nettype none
package pcs_clk_pkg;
  typedef enum logic [1:0] {
    CP_K0 = 2'h0,
    CP_D215 = 2'h1,
    CP_K1 = 2'h3,
    CP_D102 = 2'h2
  } cp_state_t;
endpackage
`default_nettype wire

/* File: verif/fabric_user.sv */
`include "pcs_clk_map.svh"
`default_nettype none

module fabric_user #(
  parameter int PW = 10
) (
  // Clock
  input wire logic mclk,
  // Receive side of the fabric
  input wire logic [2*PW-1:0] rx_data_r,
  input wire logic rx_valid_r,
  // Transmit side of the fabric
  output var logic tx_valid,
  output var logic [2*PW-1:0] tx_data,
  output var logic [1:0] tx_k,
  output logic tx_forcedisp
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2*PW-1:0] got;
  int n_got;

  // Forced disparity only beside the K28.5/D21.5 pair
  assign tx_forcedisp = tx_valid && tx_data[7:0] == `CODE_K285 &&
    tx_data[PW+7:PW] == `CODE_D215;

  initial begin
    tx_valid = 1'b0;
    tx_data = '0;
    tx_k = '0;
    got = '0;
    n_got = 0;
  end

  always @(posedge mclk) begin
    if (rx_valid_r) begin
      got <= rx_data_r;
      n_got <= n_got + 1;
    end
  end

  // Idle data is inverted so stale words never look valid
  task put(input logic v, input logic [2*PW-1:0] d, input logic [1:0] k);
    tx_valid = v;
    tx_data = v ? d : ~tx_data;
    tx_k = k;
  endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`include "pcs_clk_map.svh"
`default_nettype none
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, a); end end

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PW = 10;
  logic mclk, rst, rm, deser, bonded, rxce, comp, ls, bt, rec, rxc, p, txce, txc;
  logic pmak, pmaf, rxv, rxe, txo, rxo, tv, tf;
  logic [1:0] wsel, tk;
  logic [PW-1:0] rxpma, pmad;
  logic [2*PW-1:0] td, rxd;
  logic [19:0] m;
  logic [7:0] cp [4];
  int wl [4];
  int bad_count, n_tests, k;

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  pcs_phase_fifo_clocking #(.PW(PW), .AW(3)) dut (
    .mclk(mclk), .rst(rst), .ce(1'b1), .rate_match_en(rm), .byte_deser_en(deser),
    .bonded(bonded), .tx_coreclk_en(txce), .rx_coreclk_en(rxce), .width_sel(wsel),
    .compliance_en(comp), .tx_ls_tick(ls), .bond_tick(bt), .rec_clk(rec),
    .tx_coreclk(txc), .rx_coreclk(rxc), .tx_valid(tv), .tx_data(td), .tx_k(tk),
    .tx_forcedisp(tf), .pma_tx_data_r(pmad), .pma_tx_k_r(pmak), .pma_tx_force_r(pmaf),
    .rx_pma_data(rxpma), .rx_data_r(rxd), .rx_valid_r(rxv), .rx_err_r(rxe),
    .tx_clkout_r(txo), .rx_clkout_r(rxo));

  fabric_user #(.PW(PW)) fab (.mclk(mclk), .rx_data_r(rxd), .rx_valid_r(rxv),
    .tx_valid(tv), .tx_data(td), .tx_k(tk), .tx_forcedisp(tf));

  // One-cycle tick: 0 = tx low-speed, 1 = bonded
  task automatic pulse(input int w);
    @(posedge mclk);
    #1;
    if (w == 0) ls = 1'b1;
    else bt = 1'b1;
    @(posedge mclk);
    #1;
    ls = 1'b0;
    bt = 1'b0;
  endtask

  // Async pin edge: 0 = recovered clock with data, 1 = tx core clock, 2 = rx core clock
  task automatic pin(input int w, input logic [PW-1:0] d);
    p = rxo;
    if (w == 0) rxpma = d;
    if (w == 0) rec = 1'b1;
    else if (w == 1) txc = 1'b1;
    else rxc = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    rec = 1'b0;
    rxc = 1'b0;
    txc = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    if (w == 0) `CHK("rx_clkout", ~p, rxo)
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Whole run is about 120 cycles; this is over thirty times that
  initial begin
    #20000;
    bad_count++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    rst = 1'b1; rm = 1'b0; deser = 1'b0; bonded = 1'b0; rxce = 1'b0; comp = 1'b0;
    ls = 1'b0; bt = 1'b0; rec = 1'b0; rxc = 1'b0; wsel = 2'h3; rxpma = '0;
    txce = 1'b0;
    txc = 1'b0;
    bad_count = 0; n_tests = 0;
    cp[0] = `CODE_K285; cp[1] = `CODE_D215; cp[2] = `CODE_K285; cp[3] = `CODE_D102;
    wl[0] = 8; wl[1] = 10; wl[2] = 16; wl[3] = 20;
    repeat (12) @(posedge mclk);
    #1;
    `CHK("rx_err_rst", 1'b1, rxe)
    `CHK("pma_rst", 10'h000, pmad)
    rst = 1'b0;
    deser = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wsel = i[1:0];
      m = 20'hFFFFF >> (20 - wl[i]);
      fab.put(1'b1, 20'hFFFFF, 2'b00);
      pulse(0);
      fab.put(1'b0, 20'h00000, 2'b00);
      p = txo;
      pulse(0);
      `CHK("tx_lo", m[9:0], pmad)
      `CHK("tx_clkout", ~p, txo)
      pulse(0);
      `CHK("tx_hi", m[19:10], pmad)
    end
    fab.put(1'b1, {2'h0, `CODE_D215, 2'h0, `CODE_K285}, 2'b01);
    pulse(0);
    fab.put(1'b0, 20'h00000, 2'b00);
    pulse(0);
    `CHK("force_lo", 1'b1, pmaf)
    `CHK("k_lo", 1'b1, pmak)
    pulse(0);
    `CHK("force_hi", 1'b1, pmaf)
    `CHK("data_hi", {2'h0, `CODE_D215}, pmad)
    $display("width and split test done");
    deser = 1'b0;
    bonded = 1'b1;
    fab.put(1'b1, 20'h00155, 2'b00);
    pulse(1);
    fab.put(1'b0, 20'h00000, 2'b00);
    pulse(1);
    `CHK("bond_pop", 10'h155, pmad)
    pulse(0);
    `CHK("bond_hold", 10'h155, pmad)
    $display("bonded test done");
    bonded = 1'b0;
    // User tx core clock paces writes; low-speed ticks alone write nothing
    txce = 1'b1;
    fab.put(1'b1, 20'h00123, 2'b00);
    pulse(0);
    `CHK("tx_ls_skip", 10'h000, pmad)
    pin(1, 10'h000);
    fab.put(1'b0, 20'h00000, 2'b00);
    pulse(0);
    `CHK("tx_core", 10'h123, pmad)
    txce = 1'b0;
    $display("tx core clock test done");
    // Narrow pass, then wide pass split by the byte serializer
    for (int j = 0; j < 2; j++) begin
      wsel = (j == 0) ? 2'h1 : 2'h3;
      deser = (j != 0);
      comp = 1'b1;
      @(posedge mclk);
      #1;
      ls = 1'b1;
      @(posedge mclk);
      #1;
      for (int i = 0; i < 8; i++) begin
        @(posedge mclk);
        #1;
        `CHK("comp_code", {2'h0, cp[i % 4]}, pmad)
        `CHK("comp_k", (i % 2) == 0, pmak)
        `CHK("comp_force", (i % 4) < 2, pmaf)
      end
      // One more tick with the pattern off drains the narrow pass; the wide pass leaves words queued
      comp = 1'b0;
      @(posedge mclk);
      #1;
      ls = 1'b0;
    end
    deser = 1'b0;
    wsel = 2'h3;
    $display("compliance test done");
    rm = 1'b1;
    pin(0, 10'h2A5);
    pulse(0);
    pulse(0);
    `CHK("rm_valid", 1'b1, rxv)
    `CHK("rm_data", 20'h002A5, rxd)
    $display("rate match test done");
    // Mid-run reset empties both FIFOs and the capture stage
    rst = 1'b1;
    rm = 1'b0;
    rxce = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    `CHK("rx_err_rst2", 1'b1, rxe)
    pin(0, 10'h11B);
    pin(0, 10'h0C4);
    // First write after reset carries the cleared capture stage
    k = fab.n_got;
    pin(2, 10'h000);
    `CHK("core_count", k + 1, fab.n_got)
    pin(2, 10'h000);
    `CHK("core_count2", k + 2, fab.n_got)
    `CHK("core_data", 20'h0011B, fab.got)
    pin(2, 10'h000);
    `CHK("empty_err", 1'b1, rxe)
    `CHK("empty_count", k + 2, fab.n_got)
    $display("receive core clock test done");
    summarize();
  end
endmodule
`default_nettype wire
